// [cfgwp_regs.sv]
// capability word, linked load address, watch pairs and scratch register behind coprocessor-0 access
`timescale 1ns/1ps
module cfgwp_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // coprocessor-0 access
  input wire cfgwp_pkg::cfgwp_cp0_req_s cp0_req_i,
  output logic [31:0] rd_data_o,
  output logic rd_valid_o,
  output logic rd_mapped_o,
  // load-linked capture
  input wire logic ll_capture_i,
  input wire logic [31:0] ll_paddr_i,
  // translation state
  input wire logic [cfgwp_pkg::TAG_W-1:0] address_space_tag_i,
  input wire logic data_watch_global_i,
  input wire logic code_watch_global_i,
  // accesses to watch
  input wire cfgwp_pkg::cfgwp_acc_s data_acc_i,
  input wire cfgwp_pkg::cfgwp_acc_s fetch_acc_i,
  // watch exceptions
  output logic data_watch_hit_o,
  output logic code_watch_hit_o
);

  function automatic logic is_reg(input cfgwp_pkg::cfgwp_cp0_req_s req, input logic [4:0] num,
                                  input logic [2:0] sel);
    is_reg = (req.num == num) && (req.sel == sel);
  endfunction : is_reg

  // watch state
  logic [cfgwp_pkg::ADDR_W-1:0] data_addr_q;
  logic [cfgwp_pkg::ADDR_W-1:0] code_addr_q;
  logic data_load_en_q;
  logic data_store_en_q;
  logic code_fetch_en_q;
  logic [cfgwp_pkg::TAG_W-1:0] data_tag_q;
  logic [cfgwp_pkg::TAG_W-1:0] code_tag_q;
  logic [cfgwp_pkg::MASK_W-1:0] data_mask_q;
  logic [cfgwp_pkg::MASK_W-1:0] code_mask_q;

  // read answer and hit flops
  logic [31:0] rd_data_q;
  logic rd_valid_q;
  logic rd_mapped_q;
  logic data_hit_q;
  logic code_hit_q;

  // decode
  wire hit_cap = is_reg(cp0_req_i, cfgwp_pkg::CAP_NUM, cfgwp_pkg::CAP_SEL);
  wire hit_lla = is_reg(cp0_req_i, cfgwp_pkg::LLA_NUM, cfgwp_pkg::PLAIN_SEL);
  wire hit_daddr = is_reg(cp0_req_i, cfgwp_pkg::WADDR_NUM, cfgwp_pkg::DATA_SEL);
  wire hit_caddr = is_reg(cp0_req_i, cfgwp_pkg::WADDR_NUM, cfgwp_pkg::CODE_SEL);
  wire hit_dqual = is_reg(cp0_req_i, cfgwp_pkg::WQUAL_NUM, cfgwp_pkg::DATA_SEL);
  wire hit_cqual = is_reg(cp0_req_i, cfgwp_pkg::WQUAL_NUM, cfgwp_pkg::CODE_SEL);
  wire hit_scratch = is_reg(cp0_req_i, cfgwp_pkg::SCRATCH_NUM, cfgwp_pkg::PLAIN_SEL);
  wire any_hit = hit_cap | hit_lla | hit_daddr | hit_caddr | hit_dqual | hit_cqual | hit_scratch;

  // only writable fields see a write
  wire wr_daddr = cp0_req_i.wr & hit_daddr;
  wire wr_caddr = cp0_req_i.wr & hit_caddr;
  wire wr_dqual = cp0_req_i.wr & hit_dqual;
  wire wr_cqual = cp0_req_i.wr & hit_cqual;
  wire wr_scratch = cp0_req_i.wr & hit_scratch;
  wire [31:0] wd = cp0_req_i.wdata;

  // word-wide data stores
  logic [31:0] lla_word;
  logic [31:0] scratch_word;

  // captured only by the pipeline, never by a register write
  cfgwp_word_reg u_lla (
    .clk_i(clk_i),
    .load_i(ll_capture_i),
    .data_i(ll_paddr_i),
    .word_o(lla_word)
  );

  cfgwp_word_reg u_scratch (
    .clk_i(clk_i),
    .load_i(wr_scratch),
    .data_i(wd),
    .word_o(scratch_word)
  );

  // addresses, tags and masks have no reset value
  always_ff @(posedge clk_i)
  begin
    if (wr_daddr)
    begin
      data_addr_q <= wd[31:cfgwp_pkg::ADDR_LSB];
    end
    if (wr_caddr)
    begin
      code_addr_q <= wd[31:cfgwp_pkg::ADDR_LSB];
    end
    if (wr_dqual)
    begin
      data_tag_q <= wd[cfgwp_pkg::TAG_MSB:cfgwp_pkg::TAG_LSB];
      data_mask_q <= wd[cfgwp_pkg::MASK_MSB:cfgwp_pkg::MASK_LSB];
    end
    if (wr_cqual)
    begin
      code_tag_q <= wd[cfgwp_pkg::TAG_MSB:cfgwp_pkg::TAG_LSB];
      code_mask_q <= wd[cfgwp_pkg::MASK_MSB:cfgwp_pkg::MASK_LSB];
    end
  end

  // enables clear at reset so no stray exception fires before software sets up
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      data_load_en_q <= cfgwp_pkg::WATCH_EN_RESET;
      data_store_en_q <= cfgwp_pkg::WATCH_EN_RESET;
      code_fetch_en_q <= cfgwp_pkg::WATCH_EN_RESET;
    end
    else
    begin
      if (wr_daddr)
      begin
        data_load_en_q <= wd[cfgwp_pkg::LOAD_EN_BIT];
        data_store_en_q <= wd[cfgwp_pkg::STORE_EN_BIT];
      end
      if (wr_caddr)
      begin
        code_fetch_en_q <= wd[cfgwp_pkg::FETCH_EN_BIT];
      end
    end
  end

  // read views; reserved bits read zero
  wire [31:0] daddr_view = {data_addr_q, 1'b0, data_load_en_q, data_store_en_q};
  wire [31:0] caddr_view = {code_addr_q, code_fetch_en_q, 2'b00};
  // global bit reflects the core, not a write
  wire [31:0] dqual_view = {cfgwp_pkg::DATA_MORE_VALUE, data_watch_global_i, 6'h00, data_tag_q,
                            4'h0, data_mask_q, 3'h0};
  wire [31:0] cqual_view = {cfgwp_pkg::CODE_MORE_VALUE, code_watch_global_i, 6'h00, code_tag_q,
                            4'h0, code_mask_q, 3'h0};

  wire [31:0] rd_sel = hit_cap ? cfgwp_pkg::CAP_WORD :
                       hit_lla ? lla_word :
                       hit_daddr ? daddr_view :
                       hit_caddr ? caddr_view :
                       hit_dqual ? dqual_view :
                       hit_cqual ? cqual_view :
                       hit_scratch ? scratch_word : 32'h0;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rd_data_q <= cfgwp_pkg::RDATA_RESET;
      rd_valid_q <= 1'b0;
      rd_mapped_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= cp0_req_i.rd;
      rd_mapped_q <= cp0_req_i.rd & any_hit;
      if (cp0_req_i.rd)
      begin
        rd_data_q <= rd_sel;
      end
    end
  end

  // watch comparison
  logic data_match;
  logic code_match;

  cfgwp_watch_match u_data_match (
    .acc_addr_i(data_acc_i.watch_virtual_address[31:cfgwp_pkg::ADDR_LSB]),
    .cur_tag_i(address_space_tag_i),
    .watch_addr_i(data_addr_q),
    .watch_mask_i(data_mask_q),
    .watch_tag_i(data_tag_q),
    .watch_global_i(data_watch_global_i),
    .match_o(data_match)
  );

  cfgwp_watch_match u_code_match (
    .acc_addr_i(fetch_acc_i.watch_virtual_address[31:cfgwp_pkg::ADDR_LSB]),
    .cur_tag_i(address_space_tag_i),
    .watch_addr_i(code_addr_q),
    .watch_mask_i(code_mask_q),
    .watch_tag_i(code_tag_q),
    .watch_global_i(code_watch_global_i),
    .match_o(code_match)
  );

  wire data_kind_en = (data_acc_i.load & data_load_en_q) | (data_acc_i.store & data_store_en_q);
  wire data_hit_d = data_acc_i.valid & data_kind_en & data_match;
  wire code_hit_d = fetch_acc_i.valid & code_fetch_en_q & code_match;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      data_hit_q <= 1'b0;
      code_hit_q <= 1'b0;
    end
    else
    begin
      data_hit_q <= data_hit_d;
      code_hit_q <= code_hit_d;
    end
  end

  assign rd_data_o = rd_data_q;
  assign rd_valid_o = rd_valid_q;
  assign rd_mapped_o = rd_mapped_q;
  assign data_watch_hit_o = data_hit_q;
  assign code_watch_hit_o = code_hit_q;

endmodule : cfgwp_regs

// [cfgwp_pkg.sv]
// constants and carrier types for the capability and watchpoint register bank
// What this block does
// - The capability word reports the translation buffer size minus one, 31, in bits 30:25, read only.
// - The capability word reports code cache sets code 1, line code 4 and ways code 3 in bits 24:16, read only.
// - The capability word reports data cache sets code 1, line code 4 and ways code 3 in bits 15:7, read only.
// - Presence bits read 1 for the watch unit (bit 3) and debug port (bit 1) and 0 for all other units and bit 5.
// - The linked load address register captures the physical address of the latest load-linked and is read only.
// - The data watch address holds an address in bits 31:3, a load enable in bit 1 and a store enable in bit 0.
// - The code watch address holds an address in bits 31:3 and a fetch enable in bit 2 that resets to 0.
// - A set global bit 30 in a qualifier makes any address match hit regardless of tag, and it is read only.
// - With the global bit clear, a hit also needs the qualifier tag in bits 23:16 to equal the current tag.
// - Each set bit of the qualifier mask in bits 11:3 removes that address bit from the comparison.
// - Bit 31 of the data watch qualifier always reads 1 to show another pair at the next select.
// - The scratch register reads back the last value written with no side effect and no reset value.
package cfgwp_pkg;

  // register numbers and select indices
  localparam logic [4:0] CAP_NUM = 5'h10;
  localparam logic [4:0] LLA_NUM = 5'h11;
  localparam logic [4:0] WADDR_NUM = 5'h12;
  localparam logic [4:0] WQUAL_NUM = 5'h13;
  localparam logic [4:0] SCRATCH_NUM = 5'h16;
  localparam logic [2:0] CAP_SEL = 3'h1;
  localparam logic [2:0] PLAIN_SEL = 3'h0;
  localparam logic [2:0] DATA_SEL = 3'h0;
  localparam logic [2:0] CODE_SEL = 3'h1;

  // capability word fields, msb first
  localparam logic [5:0] TLB_SIZE_M1 = 6'h1F;
  localparam logic [2:0] CODE_SETS = 3'h1;
  localparam logic [2:0] CODE_LINE = 3'h4;
  localparam logic [2:0] CODE_WAYS = 3'h3;
  localparam logic [2:0] DATA_SETS = 3'h1;
  localparam logic [2:0] DATA_LINE = 3'h4;
  localparam logic [2:0] DATA_WAYS = 3'h3;
  localparam logic SECOND_COPROC_PRESENT = 1'b0;
  localparam logic CAP_BIT5 = 1'b0;
  localparam logic PERF_COUNTER_PRESENT = 1'b0;
  localparam logic WATCH_PRESENT = 1'b1;
  localparam logic CODE_COMPRESS_PRESENT = 1'b0;
  localparam logic DEBUG_PORT_PRESENT = 1'b1;
  localparam logic FLOAT_UNIT_PRESENT = 1'b0;
  localparam logic [31:0] CAP_WORD = {1'b0, TLB_SIZE_M1, CODE_SETS, CODE_LINE, CODE_WAYS,
                                      DATA_SETS, DATA_LINE, DATA_WAYS, SECOND_COPROC_PRESENT,
                                      CAP_BIT5, PERF_COUNTER_PRESENT, WATCH_PRESENT,
                                      CODE_COMPRESS_PRESENT, DEBUG_PORT_PRESENT, FLOAT_UNIT_PRESENT};

  // watch register field positions
  localparam int ADDR_LSB = 3;
  localparam int FETCH_EN_BIT = 2;
  localparam int LOAD_EN_BIT = 1;
  localparam int STORE_EN_BIT = 0;
  localparam int MORE_BIT = 31;
  localparam int GLOBAL_BIT = 30;
  localparam int TAG_MSB = 23;
  localparam int TAG_LSB = 16;
  localparam int MASK_MSB = 11;
  localparam int MASK_LSB = 3;
  localparam int TAG_W = TAG_MSB - TAG_LSB + 1;
  localparam int MASK_W = MASK_MSB - MASK_LSB + 1;
  localparam int ADDR_W = 32 - ADDR_LSB;

  // reset values and fixed more-bit read values
  localparam logic WATCH_EN_RESET = 1'b0;
  localparam logic DATA_MORE_VALUE = 1'b1;
  localparam logic CODE_MORE_VALUE = 1'b0;
  localparam logic [31:0] RDATA_RESET = 32'h0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] num;
    logic [2:0] sel;
    logic [31:0] wdata;
  } cfgwp_cp0_req_s;

  typedef struct packed {
    logic valid;
    logic load;
    logic store;
    logic [31:0] watch_virtual_address;
  } cfgwp_acc_s;

endpackage : cfgwp_pkg

// [cfgwp_word_reg.sv]
// a 32-bit data word with load enable and no reset, for contents that are unpredictable after reset
`timescale 1ns/1ps
module cfgwp_word_reg (
  // clock
  input wire logic clk_i,
  // load
  input wire logic load_i,
  input wire logic [31:0] data_i,
  // stored word
  output logic [31:0] word_o
);

  logic [31:0] word_q;

  always_ff @(posedge clk_i)
  begin
    if (load_i)
    begin
      word_q <= data_i;
    end
  end

  assign word_o = word_q;

endmodule : cfgwp_word_reg

// [cfgwp_watch_match.sv]
// masked address and tag comparison for one watch pair
`timescale 1ns/1ps
module cfgwp_watch_match (
  // access under test
  input wire logic [cfgwp_pkg::ADDR_W-1:0] acc_addr_i,
  input wire logic [cfgwp_pkg::TAG_W-1:0] cur_tag_i,
  // watch pair contents
  input wire logic [cfgwp_pkg::ADDR_W-1:0] watch_addr_i,
  input wire logic [cfgwp_pkg::MASK_W-1:0] watch_mask_i,
  input wire logic [cfgwp_pkg::TAG_W-1:0] watch_tag_i,
  input wire logic watch_global_i,
  // result, before the access enables
  output logic match_o
);

  logic [cfgwp_pkg::ADDR_W-1:0] care;
  logic addr_eq;
  logic tag_ok;

  assign care = ~{{(cfgwp_pkg::ADDR_W - cfgwp_pkg::MASK_W){1'b0}}, watch_mask_i};
  assign addr_eq = ((acc_addr_i ^ watch_addr_i) & care) == '0;
  assign tag_ok = watch_global_i | (watch_tag_i == cur_tag_i);
  assign match_o = addr_eq & tag_ok;

endmodule : cfgwp_watch_match

// [cfgwp_regs_checker.sv]
// assertions on the capability and watch register bank ports
`timescale 1ns/1ps
module cfgwp_regs_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // observed ports
  input wire cfgwp_pkg::cfgwp_cp0_req_s cp0_req_i,
  input wire logic [31:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic rd_mapped_o,
  input wire logic ll_capture_i,
  input wire logic [31:0] ll_paddr_i,
  input wire cfgwp_pkg::cfgwp_acc_s data_acc_i,
  input wire cfgwp_pkg::cfgwp_acc_s fetch_acc_i,
  input wire logic data_watch_hit_o,
  input wire logic code_watch_hit_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  wire rd = cp0_req_i.rd;
  wire [4:0] n = cp0_req_i.num;
  wire [2:0] s = cp0_req_i.sel;
  wire cap_rd = rd && n == cfgwp_pkg::CAP_NUM && s == cfgwp_pkg::CAP_SEL;
  wire dacc = data_acc_i.valid && (data_acc_i.load || data_acc_i.store);
  AST_RD_ANSWER: assert property (rd |=> rd_valid_o) else $error("read not answered");
  AST_RD_QUIET: assert property (!rd |=> !rd_valid_o) else $error("spurious read valid");
  AST_CAP_WORD: assert property (cap_rd |=> rd_mapped_o && rd_data_o == cfgwp_pkg::CAP_WORD)
    else $error("capability word wrong");
  AST_DQ_MORE: assert property (rd && n == 5'h13 && s == 3'h0 |=> rd_data_o[31])
    else $error("more bit not set");
  AST_LLA: assert property (ll_capture_i ##1 (rd && n == 5'h11 && s == 3'h0 && !ll_capture_i)
    |=> rd_data_o == $past(ll_paddr_i, 2)) else $error("linked address wrong");
  AST_DATA_IDLE: assert property (!dacc |=> !data_watch_hit_o) else $error("data hit without access");
  AST_CODE_IDLE: assert property (!fetch_acc_i.valid |=> !code_watch_hit_o) else $error("code hit without fetch");
  AST_CODE_LOW: assert property (rd && n == 5'h12 && s == 3'h1 |=> rd_data_o[1:0] == 2'h0)
    else $error("code address low bits set");
  COV_CAP: cover property (cap_rd);
  COV_DHIT: cover property (data_watch_hit_o);
  COV_CHIT: cover property (code_watch_hit_o);
endmodule : cfgwp_regs_checker

bind cfgwp_regs cfgwp_regs_checker i_cfgwp_regs_checker (.clk_i(clk_i), .reset_i(reset_i),
  .cp0_req_i(cp0_req_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .rd_mapped_o(rd_mapped_o),
  .ll_capture_i(ll_capture_i), .ll_paddr_i(ll_paddr_i), .data_acc_i(data_acc_i), .fetch_acc_i(fetch_acc_i),
  .data_watch_hit_o(data_watch_hit_o), .code_watch_hit_o(code_watch_hit_o));

// [cfgwp_core_model.sv]
// core-side model: coprocessor-0 requests, load-linked capture, watched accesses
`timescale 1ns/1ps
module cfgwp_core_model (
  // clock
  input wire logic clk_i,
  // towards the register bank
  output cfgwp_pkg::cfgwp_cp0_req_s cp0_req_o,
  output logic ll_capture_o,
  output logic [31:0] ll_paddr_o,
  output logic [7:0] tag_o,
  output logic dglob_o,
  output logic cglob_o,
  output cfgwp_pkg::cfgwp_acc_s data_acc_o,
  output cfgwp_pkg::cfgwp_acc_s fetch_acc_o
);
  initial
  begin
    cp0_req_o = '0;
    ll_capture_o = 1'b0;
    ll_paddr_o = 32'h0;
    tag_o = 8'h0;
    dglob_o = 1'b0;
    cglob_o = 1'b0;
    data_acc_o = '0;
    fetch_acc_o = '0;
  end
  // each request is set after a falling edge and held through the rising edge
  // a register request also ends a capture pulse, so a capture lasts exactly one edge
  task automatic cp0(input logic wr, input logic rd, input logic [4:0] n, input logic [2:0] s, input logic [31:0] d);
    @(negedge clk_i);
    cp0_req_o = '{wr, rd, n, s, d};
    ll_capture_o = 1'b0;
    @(posedge clk_i);
  endtask : cp0
  task automatic acc(input logic code, input logic ld, input logic st, input logic [31:0] va,
                     input logic [7:0] t, input logic g);
    @(negedge clk_i);
    tag_o = t;
    if (code)
    begin
      cglob_o = g;
      fetch_acc_o = '{1'b1, 1'b0, 1'b0, va};
    end
    else
    begin
      dglob_o = g;
      data_acc_o = '{1'b1, ld, st, va};
    end
    @(posedge clk_i);
  endtask : acc
  task automatic ll(input logic [31:0] pa);
    @(negedge clk_i);
    ll_capture_o = 1'b1;
    ll_paddr_o = pa;
    @(posedge clk_i);
  endtask : ll
  // released lines flip so a stale value cannot pass for a held one
  task automatic idle();
    @(negedge clk_i);
    cp0_req_o = '{1'b0, 1'b0, cp0_req_o.num, cp0_req_o.sel, ~cp0_req_o.wdata};
    data_acc_o.valid = 1'b0;
    fetch_acc_o.valid = 1'b0;
    ll_capture_o = 1'b0;
    ll_paddr_o = ~ll_paddr_o;
  endtask : idle
endmodule : cfgwp_core_model

// [tb_cfgwp_regs.sv]
// self-checking bench for the capability and watch register bank
`timescale 1ns/1ps
module tb_cfgwp_regs;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  cfgwp_pkg::cfgwp_cp0_req_s req;
  cfgwp_pkg::cfgwp_acc_s dacc;
  cfgwp_pkg::cfgwp_acc_s facc;
  logic [31:0] ll_pa, rdata, wa, wq, va;
  logic [7:0] tag, t;
  logic ll_cap, dg, cg, rvalid, rmapped, dhit, chit, g, ld, st;
  int n_mismatch = 0;
  int checked = 0;
  int seed = 21;
  initial forever #2 clk_i = ~clk_i;
  cfgwp_core_model i_cfgwp_core_model (.clk_i(clk_i), .cp0_req_o(req), .ll_capture_o(ll_cap),
    .ll_paddr_o(ll_pa), .tag_o(tag), .dglob_o(dg), .cglob_o(cg), .data_acc_o(dacc), .fetch_acc_o(facc));
  cfgwp_regs i_cfgwp_regs (.clk_i(clk_i), .reset_i(reset_i), .cp0_req_i(req), .rd_data_o(rdata),
    .rd_valid_o(rvalid), .rd_mapped_o(rmapped), .ll_capture_i(ll_cap), .ll_paddr_i(ll_pa),
    .address_space_tag_i(tag), .data_watch_global_i(dg), .code_watch_global_i(cg), .data_acc_i(dacc),
    .fetch_acc_i(facc), .data_watch_hit_o(dhit), .code_watch_hit_o(chit));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk
  task automatic wr(input logic [4:0] n, input logic [2:0] s, input logic [31:0] d);
    i_cfgwp_core_model.cp0(1'b1, 1'b0, n, s, d);
  endtask : wr
  task automatic rd(input logic [4:0] n, input logic [2:0] s, input logic m);
    i_cfgwp_core_model.cp0(1'b0, 1'b1, n, s, 32'h0);
    i_cfgwp_core_model.idle();
    chk({30'h0, rvalid, rmapped}, {30'h0, 1'b1, m});
  endtask : rd
  function automatic logic [31:0] cap_exp();
    return {1'b0, 6'h1F, 3'h1, 3'h4, 3'h3, 3'h1, 3'h4, 3'h3, 7'h0A};
  endfunction : cap_exp
  // k holds the access kinds {fetch, load, store} lined up with the enable bits
  function automatic logic hit_exp(logic [31:0] a, logic [31:0] q, logic [31:0] v, logic [2:0] k,
                                   logic gl, logic [7:0] ct);
    return |(k & a[2:0]) && (((v[31:3] ^ a[31:3]) & ~{20'h0, q[11:3]}) == 29'h0) && (gl || q[23:16] == ct);
  endfunction : hit_exp
  task automatic end_of_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial
  begin
    #40000;
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i) reset_i = 1'b0;
    rd(5'h12, 3'h0, 1'b1);
    chk(rdata[1:0], 2'h0);
    rd(5'h12, 3'h1, 1'b1);
    chk(rdata[2], 1'b0);
    rd(5'h10, 3'h1, 1'b1);
    chk(rdata, cap_exp());
    wr(5'h10, 3'h1, 32'hFFFFFFFF);
    rd(5'h10, 3'h1, 1'b1);
    chk(rdata, cap_exp());
    rd(5'h1F, 3'h0, 1'b0);
    chk(rdata, 32'h0);
    repeat (6)
    begin
      va = $random(seed);
      i_cfgwp_core_model.ll(va);
      rd(5'h11, 3'h0, 1'b1);
      chk(rdata, va);
      wr(5'h11, 3'h0, ~va);
      rd(5'h11, 3'h0, 1'b1);
      chk(rdata, va);
      wa = $random(seed);
      wr(5'h16, 3'h0, wa);
      rd(5'h16, 3'h0, 1'b1);
      chk(rdata, wa);
    end
    repeat (400)
    begin
      g = $random(seed);
      wa = $random(seed);
      wq = $random(seed);
      va = wa ^ ($random(seed) & 32'h80000C38);
      t = $random(seed) % 2 ? wq[23:16] : $random(seed);
      {ld, st} = $random(seed);
      wr(5'h12, {2'h0, g}, wa);
      wr(5'h13, {2'h0, g}, wq);
      rd(5'h13, {2'h0, g}, 1'b1);
      chk(rdata & 32'h80FF0FF8, {~g, 7'h0, wq[23:16], 4'h0, wq[11:3], 3'h0});
      chk(rdata[30], g ? cg : dg);
      i_cfgwp_core_model.acc(g, ld, st, va, t, ^wq[31:28]);
      i_cfgwp_core_model.idle();
      chk(g ? chit : dhit, hit_exp(wa, wq, va, g ? 3'h4 : {1'b0, ld, st}, ^wq[31:28], t));
    end
    end_of_test();
  end
endmodule : tb_cfgwp_regs
